// [rgvb_regulator_ctrl.sv]
// Regulator control register and bus-power detect logic.
// Assumes a byte-wide special register port on ref_clk; inputs other than bus_power_in synchronous.
//
// Summary of operation
// - Bit 7 set turns regulator off.
// - Bit 6 reads live bus-power level.
// - Bit 5 picks interrupt polarity.
// - Enabled interrupt fires when level matches polarity.
// - Interrupt is level only, no pending flag.
// - Bit 4 selects low-power regulator mode.
// - Low four bits read zero, write zero.
// - Reset request on match when enabled.
`timescale 1ns/1ps
`include "rgvb_defs.svh"
module rgvb_regulator_ctrl (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// Special register port
	input  wire logic [7:0]        sfr_addr,
	input  wire logic              sfr_wr,
	input  wire logic              sfr_rd,
	input  wire rgvb_pkg::rgvb_byte_t sfr_wdata,
	output rgvb_pkg::rgvb_byte_t   sfr_rdata,
	// Bus-power input and system enables
	input  wire logic              bus_power_in,
	input  wire logic              bus_power_irq_en,
	input  wire logic              usb_reset_src_en,
	// Regulator and system outputs
	output logic                   regulator_off,
	output logic                   regulator_low_power_select,
	output logic                   bus_power_irq,
	output logic                   bus_power_reset_req
);
	rgvb_sync_if lvl_if ();
	logic level_s;

	assign lvl_if.raw_level = bus_power_in;
	assign level_s = lvl_if.sync_level;

	rgvb_sync #(
		.STAGES(`RGVB_SYNC_STAGES)
	) u_sync (
		.ref_clk(ref_clk),
		.rst    (rst),
		.lvl    (lvl_if)
	);

	// Field masks derived from the bit positions; reserved mask and reset value taken from the header
	localparam logic [7:0] RSVD_MASK   = `RGVB_RSVD_MASK;
	localparam logic [7:0] RESET_VALUE = `RGVB_REG_CTRL_RESET;
	localparam logic [7:0] OFF_MASK    = 8'h01 << `RGVB_BIT_REG_OFF;
	localparam logic [7:0] LEVEL_MASK  = 8'h01 << `RGVB_BIT_BUS_LEVEL;
	localparam logic [7:0] POL_MASK    = 8'h01 << `RGVB_BIT_POLARITY;
	localparam logic [7:0] LP_MASK     = 8'h01 << `RGVB_BIT_LOW_POWER;
	localparam logic [7:0] STORE_MASK  = OFF_MASK | POL_MASK | LP_MASK;
	localparam logic [7:0] FIELD_MASK  = STORE_MASK | LEVEL_MASK;

	// Refuse a header layout that the logic below cannot serve
	if (`RGVB_SYNC_STAGES < 2) begin
		$error("Bus-power synchroniser needs two stages or more");
	end
	if ($countones(FIELD_MASK) != 4) begin
		$error("Control fields must sit on four distinct bits");
	end
	if ((FIELD_MASK & RSVD_MASK) != 8'h00) begin
		$error("A control field overlaps the reserved bits");
	end
	if ((FIELD_MASK | RSVD_MASK) != 8'hff) begin
		$error("A register bit is left without a meaning");
	end
	if ((RESET_VALUE & RSVD_MASK) != 8'h00) begin
		$error("Reset value sets reserved bits");
	end
	if ((RESET_VALUE & LEVEL_MASK) != 8'h00) begin
		$error("Reset value sets the live status bit");
	end

	// Register decode; a read in the cycle of a write sees the old value
	// Only one register, so the decode is a plain compare
	logic wr_hit;
	logic rd_hit;

	always_comb begin
		wr_hit = sfr_wr && (sfr_addr == `RGVB_REG_CTRL_ADDR);
		rd_hit = sfr_rd && (sfr_addr == `RGVB_REG_CTRL_ADDR);
	end

	// Regulator off; held until rewritten
	logic reg_off_q;
	logic reg_off_d;

	always_comb begin
		reg_off_d = reg_off_q;
		if (wr_hit) begin
			reg_off_d = sfr_wdata[`RGVB_BIT_REG_OFF];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_off_q <= RESET_VALUE[`RGVB_BIT_REG_OFF];
		end else begin
			reg_off_q <= reg_off_d;
		end
	end

	// Interrupt and reset polarity
	logic polarity_q;
	logic polarity_d;

	always_comb begin
		polarity_d = polarity_q;
		if (wr_hit) begin
			polarity_d = sfr_wdata[`RGVB_BIT_POLARITY];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			polarity_q <= RESET_VALUE[`RGVB_BIT_POLARITY];
		end else begin
			polarity_q <= polarity_d;
		end
	end

	// Low-power regulator mode, meant for suspend
	logic low_power_q;
	logic low_power_d;

	always_comb begin
		low_power_d = low_power_q;
		if (wr_hit) begin
			low_power_d = sfr_wdata[`RGVB_BIT_LOW_POWER];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			low_power_q <= RESET_VALUE[`RGVB_BIT_LOW_POWER];
		end else begin
			low_power_q <= low_power_d;
		end
	end

	// Read data; the status bit and low nibble are never stored
	rgvb_pkg::rgvb_byte_t image;
	rgvb_pkg::rgvb_byte_t rdata_q;
	rgvb_pkg::rgvb_byte_t rdata_d;

	always_comb begin
		image                      = 8'h00;
		image[`RGVB_BIT_REG_OFF]   = reg_off_q;
		image[`RGVB_BIT_BUS_LEVEL] = level_s;
		image[`RGVB_BIT_POLARITY]  = polarity_q;
		image[`RGVB_BIT_LOW_POWER] = low_power_q;
		// Masking keeps the reserved nibble zero whatever the fields hold
		image                      = image & ~RSVD_MASK;
		// Zero when idle, so a shared read path can OR its sources
		rdata_d = 8'h00;
		if (rd_hit) begin
			rdata_d = image;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Match of level and polarity, shared by both events
	logic match;

	always_comb begin
		// Polarity 1 matches a high level, 0 a low one
		match = (level_s == polarity_q);
	end

	// Interrupt; recomputed each cycle, no pending flag
	// Level only: an enable raised during a match fires at the next clock edge
	logic irq_q;
	logic irq_d;

	always_comb begin
		irq_d = match && bus_power_irq_en;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// Reset request; the reset controller decides what it resets
	// Stays high while matched, so the system reset is held
	logic rst_req_q;
	logic rst_req_d;

	always_comb begin
		rst_req_d = match && usb_reset_src_en;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rst_req_q <= 1'b0;
		end else begin
			rst_req_q <= rst_req_d;
		end
	end

	// Every output straight from a flip-flop
	assign sfr_rdata                  = rdata_q;
	assign regulator_off              = reg_off_q;
	assign regulator_low_power_select = low_power_q;
	assign bus_power_irq              = irq_q;
	assign bus_power_reset_req        = rst_req_q;
endmodule

// [rgvb_defs.svh]
// Constants for the regulator control and bus-power detect block.
// Assumes inclusion by bare name from the same folder.
`ifndef RGVB_DEFS_SVH
`define RGVB_DEFS_SVH

`define RGVB_REG_CTRL_ADDR   8'hc9
`define RGVB_REG_CTRL_RESET  8'h00
`define RGVB_BIT_REG_OFF     7
`define RGVB_BIT_BUS_LEVEL   6
`define RGVB_BIT_POLARITY    5
`define RGVB_BIT_LOW_POWER   4
`define RGVB_RSVD_MASK       8'h0f
`define RGVB_SYNC_STAGES     2

`endif

// [rgvb_pkg.sv]
// Types for the regulator control and bus-power detect block.
// Assumes nothing of its surroundings.
package rgvb_pkg;
	typedef logic [7:0] rgvb_byte_t;
endpackage

// [rgvb_sync_if.sv]
// Carrier between the top module and its input synchroniser.
// Assumes one clock domain.
`timescale 1ns/1ps
interface rgvb_sync_if;
	logic raw_level;
	logic sync_level;
	modport src (output raw_level, input sync_level);
	modport snk (input raw_level, output sync_level);
endinterface

// [rgvb_sync.sv]
// Level synchroniser for the bus-power input.
// Assumes ref_clk and an active-high asynchronous rst.
`timescale 1ns/1ps
`include "rgvb_defs.svh"
module rgvb_sync #(
	parameter int STAGES = `RGVB_SYNC_STAGES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Levels
	rgvb_sync_if.snk lvl
);
	// Elaboration check: one stage gives no metastability margin
	if (STAGES < 2) begin
		$error("rgvb_sync needs at least two stages");
	end

	logic [STAGES-1:0] chain_q;
	logic [STAGES-1:0] chain_d;

	// Only the last stage is read downstream
	always_comb begin
		chain_d = {chain_q[STAGES-2:0], lvl.raw_level};
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			chain_q <= '0;
		end else begin
			chain_q <= chain_d;
		end
	end

	assign lvl.sync_level = chain_q[STAGES-1];
endmodule

// [rgvb_host.sv]
// Model of the host that supplies bus power.
// Assumes attach comes from the bench on ref_clk.
`timescale 1ns/1ps
module rgvb_host (
	input  wire logic ref_clk,
	input  wire logic attach,
	output logic      vbus
);
	// Supply lags attach by a cycle, like a slow cable
	initial vbus = 1'b0;
	always @(posedge ref_clk) vbus <= attach;
endmodule

// [rgvb_asserts.sv]
// Checker for the regulator control block.
// Assumes a bind to the top module.
`timescale 1ns/1ps
module rgvb_chk (
	// Clock and reset
	input wire logic                 ref_clk,
	input wire logic                 rst,
	// Register port
	input wire logic [7:0]           sfr_addr,
	input wire logic                 sfr_wr,
	input wire logic                 sfr_rd,
	input wire rgvb_pkg::rgvb_byte_t sfr_wdata,
	input wire rgvb_pkg::rgvb_byte_t sfr_rdata,
	// Bus-power input and enables
	input wire logic                 bus_power_in,
	input wire logic                 bus_power_irq_en,
	input wire logic                 usb_reset_src_en,
	// Regulator and system outputs
	input wire logic                 regulator_off,
	input wire logic                 regulator_low_power_select,
	input wire logic                 bus_power_irq,
	input wire logic                 bus_power_reset_req
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire w = sfr_wr && sfr_addr == 8'hc9;
	wire r = sfr_rd && sfr_addr == 8'hc9;
	property p_off; w |=> regulator_off == $past(sfr_wdata[7]); endproperty
	a_off: assert property (p_off) else $error("off bit");
	property p_lp; w |=> regulator_low_power_select == $past(sfr_wdata[4]); endproperty
	a_lp: assert property (p_lp) else $error("mode bit");
	property p_rsv; r |=> sfr_rdata[3:0] == 4'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("low bits");
	property p_rb; r |=> sfr_rdata[7] == $past(regulator_off) && sfr_rdata[4] == $past(regulator_low_power_select); endproperty
	a_rb: assert property (p_rb) else $error("readback");
	property p_idle; !r |=> sfr_rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("idle data");
	property p_irq; !bus_power_irq_en [*2] |-> !bus_power_irq; endproperty
	a_irq: assert property (p_irq) else $error("irq gate");
	property p_rr; !usb_reset_src_en [*2] |-> !bus_power_reset_req; endproperty
	a_rr: assert property (p_rr) else $error("reset gate");
	property p_same; (bus_power_irq_en && usb_reset_src_en) [*2] |-> bus_power_irq == bus_power_reset_req; endproperty
	a_same: assert property (p_same) else $error("irq and reset differ");
	property p_lvl; $stable(bus_power_in) [*4] ##0 r |=> sfr_rdata[6] == $past(bus_power_in); endproperty
	a_lvl: assert property (p_lvl) else $error("level bit");
	c_irq: cover property (bus_power_irq);
	c_rr: cover property (bus_power_reset_req);
	c_rd: cover property (r ##1 sfr_rdata[6]);
endmodule
bind rgvb_regulator_ctrl rgvb_chk u_chk (
	.ref_clk                   (ref_clk),
	.rst                       (rst),
	.sfr_addr                  (sfr_addr),
	.sfr_wr                    (sfr_wr),
	.sfr_rd                    (sfr_rd),
	.sfr_wdata                 (sfr_wdata),
	.sfr_rdata                 (sfr_rdata),
	.bus_power_in              (bus_power_in),
	.bus_power_irq_en          (bus_power_irq_en),
	.usb_reset_src_en          (usb_reset_src_en),
	.regulator_off             (regulator_off),
	.regulator_low_power_select(regulator_low_power_select),
	.bus_power_irq             (bus_power_irq),
	.bus_power_reset_req       (bus_power_reset_req)
);

// [tb.sv]
// Self-checking bench for the regulator control block.
// Assumes the host model drives the bus-power input.
`timescale 1ns/1ps
module tb;
	logic ref_clk = 0, rst = 1, wr = 0, rd_s = 0, attach = 0, irq_en = 0, rs_en = 0;
	logic [7:0] addr = 8'h00, q;
	rgvb_pkg::rgvb_byte_t wdata = 8'h00, rdata;
	logic off, lp, irq, rreq, vbus;
	int n_errors = 0, checks = 0;
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t %h %h", $time, a, e); end end
	rgvb_host u_host (.ref_clk(ref_clk), .attach(attach), .vbus(vbus));
	rgvb_regulator_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd_s),
		.sfr_wdata(wdata), .sfr_rdata(rdata), .bus_power_in(vbus), .bus_power_irq_en(irq_en),
		.usb_reset_src_en(rs_en), .regulator_off(off), .regulator_low_power_select(lp),
		.bus_power_irq(irq), .bus_power_reset_req(rreq));
	initial forever #12.5 ref_clk = ~ref_clk;
	task automatic w(input logic [7:0] a, d);
		@(negedge ref_clk) {wr, addr, wdata} = {1'b1, a, d};
		@(negedge ref_clk) wr = 1'b0;
	endtask
	task automatic r(input logic [7:0] a);
		@(negedge ref_clk) {rd_s, addr} = {1'b1, a};
		@(negedge ref_clk) q = rdata;
		rd_s = 1'b0;
	endtask
	task automatic t_ctrl;
		w(8'hc9, 8'h90);
		`CHK({off, lp}, 2'b11)
		r(8'hc9);
		`CHK(q, 8'h90)
		w(8'hc9, 8'h40);
		r(8'hc9);
		`CHK(q, 8'h00)
		$display("t_ctrl done");
	endtask
	task automatic t_addr;
		w(8'hc8, 8'h80);
		`CHK(off, 1'b0)
		r(8'hc8);
		`CHK(q, 8'h00)
		$display("t_addr done");
	endtask
	task automatic t_reset;
		w(8'hc9, 8'hb0);
		`CHK({off, lp}, 2'b11)
		@(negedge ref_clk) rst = 1'b1;
		@(negedge ref_clk) `CHK({off, lp, irq, rreq, rdata}, 12'h000)
		rst = 1'b0;
		r(8'hc9);
		`CHK(q, 8'h00)
		$display("t_reset done");
	endtask
	task automatic t_vbus;
		{irq_en, rs_en} = 2'b11;
		for (int p = 0; p < 2; p++) begin
			w(8'hc9, {2'b00, p[0], 5'h00});
			for (int v = 0; v < 2; v++) begin
				attach = v[0];
				repeat (6) @(negedge ref_clk);
				r(8'hc9);
				`CHK(q[6:5], {v[0], p[0]})
				`CHK({irq, rreq}, {2{v[0] == p[0]}})
			end
		end
		irq_en = 1'b0;
		repeat (2) @(negedge ref_clk);
		`CHK({irq, rreq}, 2'b01)
		$display("t_vbus done");
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#100us;
		n_errors++;
		end_of_test();
	end
	initial begin
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		t_ctrl();
		t_addr();
		t_reset();
		t_vbus();
		end_of_test();
	end
endmodule
